// ---- src/iasr_pkg.sv ----
`default_nettype none

// Shared constants for the target address and soft reset register bank
package iasr_pkg;

  // Register offsets on the serial control bus
  localparam logic [7:0] OWN_ADDR_OFFSET     = 8'h00;
  localparam logic [7:0] RESET_CTRL_OFFSET   = 8'h01;

  // Field positions
  localparam int         SRC_SEL_POS         = 0;    // Address source select
  localparam int         FIELD_LSB           = 1;    // Target address field 7:1
  localparam int         LOGIC_RST_POS       = 0;    // Logic-only reset
  localparam int         FULL_RST_POS        = 1;    // Full logic and register reset
  localparam int         VIDEO_RST_POS       = 4;    // Video input receiver reset

  // Writable bits of the reset register, all others reserved
  localparam logic [7:0] RESET_CTRL_WRITABLE = 8'h13;

  // Reset values
  localparam logic       SRC_SEL_RESET       = 1'b0;
  localparam logic [2:0] RST_BITS_RESET      = 3'h0;
  localparam logic [7:0] UNMAPPED_READ       = 8'h00;

  // Timing
  localparam int CLK_PERIOD_NS      = 50;
  localparam int RESET_PULSE_NS     = 1000;
  localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STRAP_SETTLE       = 3;  // Cycles after release before strap capture

  // Serial target states
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_WR_BYTE  = 3'b011,
    ST_WR_ACK   = 3'b100,
    ST_RD_BYTE  = 3'b101,
    ST_RD_ACK   = 3'b110
  } iasr_state_t;

endpackage

`default_nettype wire

// ---- src/iasr_i2c_target.sv ----
`default_nettype none

// Serial bus target: address match, register pointer, write strobes, reads
module iasr_i2c_target (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       scl_in,     // Raw clock pin
  input  wire logic       sda_in,     // Raw data pin
  output logic            sda_oe,     // High pulls data low
  input  wire logic [6:0] dev_addr,   // Address to answer at
  output logic [7:0]      reg_ptr,    // Register pointer, auto-increments
  input  wire logic [7:0] rd_data,    // Register content at reg_ptr
  output logic            wr_stb,     // One-cycle write pulse
  output logic [7:0]      wr_addr,    // Write offset
  output logic [7:0]      wr_data     // Write value
);

  logic scl_s1, scl_s2, scl_d;        // Clock pin synchroniser and delay
  logic sda_s1, sda_s2, sda_d;        // Data pin synchroniser and delay
  iasr_pkg::iasr_state_t state;       // Bus state
  logic [3:0] bit_cnt;                // Rising clock edges in this byte
  logic [7:0] shift;                  // Received bits
  logic [7:0] tx;                     // Bits still to send
  logic       rd_mode;                // Read transfer
  logic       first_byte;             // Next written byte is the pointer

  // Two-stage synchronisers; stage two and its delayed copy feed logic
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {scl_s1, scl_s2, scl_d} <= 3'h7;
      {sda_s1, sda_s2, sda_d} <= 3'h7;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d  <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d  <= sda_s2;
    end
  end

  wire start_cond = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire stop_cond  = scl_s2 & scl_d & ~sda_d & sda_s2;
  wire scl_rise   = scl_s2 & ~scl_d;
  wire scl_fall   = ~scl_s2 & scl_d;

  // Bus state machine; data changes only after the clock falls
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state      <= iasr_pkg::ST_IDLE;
      bit_cnt    <= 4'h0;
      shift      <= 8'h00;
      tx         <= 8'h00;
      rd_mode    <= 1'b0;
      first_byte <= 1'b0;
      sda_oe     <= 1'b0;
      reg_ptr    <= 8'h00;
      wr_stb     <= 1'b0;
      wr_addr    <= 8'h00;
      wr_data    <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      // Sample on every rising edge
      if (scl_rise) begin
        shift   <= {shift[6:0], sda_s2};
        bit_cnt <= bit_cnt + 4'h1;
      end
      if (start_cond) begin
        // Start or repeated start; pointer is kept
        state   <= iasr_pkg::ST_ADDR;
        bit_cnt <= 4'h0;
        sda_oe  <= 1'b0;
      end else if (stop_cond) begin
        state  <= iasr_pkg::ST_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_fall) begin
        case (state)
          iasr_pkg::ST_ADDR: begin
            // Acknowledge only our own address
            if (bit_cnt == 4'h8 && shift[7:1] == dev_addr) begin
              sda_oe  <= 1'b1;
              rd_mode <= shift[0];
              state   <= iasr_pkg::ST_ADDR_ACK;
            end else if (bit_cnt == 4'h8) begin
              state <= iasr_pkg::ST_IDLE;
            end
          end
          iasr_pkg::ST_ADDR_ACK: begin
            bit_cnt <= 4'h0;
            if (rd_mode) begin
              sda_oe <= ~rd_data[7];
              tx     <= {rd_data[6:0], 1'b0};
              state  <= iasr_pkg::ST_RD_BYTE;
            end else begin
              sda_oe     <= 1'b0;
              first_byte <= 1'b1;
              state      <= iasr_pkg::ST_WR_BYTE;
            end
          end
          iasr_pkg::ST_WR_BYTE: begin
            if (bit_cnt == 4'h8) begin
              sda_oe <= 1'b1;
              state  <= iasr_pkg::ST_WR_ACK;
              if (first_byte) begin
                reg_ptr    <= shift;
                first_byte <= 1'b0;
              end else begin
                wr_stb  <= 1'b1;
                wr_addr <= reg_ptr;
                wr_data <= shift;
                reg_ptr <= reg_ptr + 8'h01;
              end
            end
          end
          iasr_pkg::ST_WR_ACK: begin
            sda_oe  <= 1'b0;
            bit_cnt <= 4'h0;
            state   <= iasr_pkg::ST_WR_BYTE;
          end
          iasr_pkg::ST_RD_BYTE: begin
            if (bit_cnt == 4'h8) begin
              // Release for the controller's acknowledge
              sda_oe  <= 1'b0;
              reg_ptr <= reg_ptr + 8'h01;
              state   <= iasr_pkg::ST_RD_ACK;
            end else begin
              sda_oe <= ~tx[7];
              tx     <= {tx[6:0], 1'b0};
            end
          end
          iasr_pkg::ST_RD_ACK: begin
            // Low bit sampled low means the controller wants more
            if (!shift[0]) begin
              sda_oe  <= ~rd_data[7];
              tx      <= {rd_data[6:0], 1'b0};
              bit_cnt <= 4'h0;
              state   <= iasr_pkg::ST_RD_BYTE;
            end else begin
              state <= iasr_pkg::ST_IDLE;
            end
          end
          default: state <= iasr_pkg::ST_IDLE;
        endcase
      end
    end
  end

endmodule // iasr_i2c_target

`default_nettype wire

// ---- src/iasr_regs.sv ----
`default_nettype none

// What this block does
// - Hold 7-bit target address, strap default
// - Bit 0 picks strap or programmed address
// - Bit 4 resets video receiver, self-clears
// - Bit 1 resets all logic and registers
// - Bit 0 resets logic and restores the address register
// - Logic-only reset reloads strapped values
// - Logic-only reset restores listed registers
module iasr_regs #(
  parameter int PULSE_CYCLES = iasr_pkg::RESET_PULSE_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,                        // Always low when enabled
  output logic            sda_oe,                         // High pulls data low
  input  wire logic [6:0] address_strap_pin,              // Strapped address level
  output logic [6:0]      active_target_address,          // Address answered at
  output logic            video_rx_reset,                 // Video receiver reset
  output logic            full_logic_and_register_reset,  // Whole-block reset
  output logic            logic_only_reset                // Logic reset, address register restored
);

  logic [6:0] strap_s1, strap_s2;      // Strap synchroniser
  logic [6:0] strap_orig;              // Strap caught after release
  logic [1:0] settle_cnt;              // Wait for synchroniser to fill
  logic       strap_valid;             // Strap has been caught
  logic [6:0] target_address_field;    // Programmed address
  logic       address_source_select;   // 0 strap, 1 programmed
  logic [2:0] rst_bit;                 // {video, full, logic} reset bits
  logic [2:0] rst_req;                 // Write requests for those bits
  logic [7:0] reg_ptr;
  logic [7:0] rd_data;
  logic       wr_stb;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic       oe_int;

  iasr_i2c_target u_target (
    .clk      (clk),
    .reset    (reset),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .sda_oe   (oe_int),
    .dev_addr (active_target_address),
    .reg_ptr  (reg_ptr),
    .rd_data  (rd_data),
    .wr_stb   (wr_stb),
    .wr_addr  (wr_addr),
    .wr_data  (wr_data)
  );

  assign sda_oe = oe_int;

  // Open-drain data: the level driven is always low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // Strap pin synchroniser
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strap_s1 <= 7'h00;
      strap_s2 <= 7'h00;
    end else begin
      strap_s1 <= address_strap_pin;
      strap_s2 <= strap_s1;
    end
  end

  // Full reset recatches strap
  // Strap is caught after release, never under the asynchronous reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      settle_cnt  <= 2'h0;
      strap_valid <= 1'b0;
      strap_orig  <= 7'h00;
    end else if (rst_bit[iasr_pkg::FULL_RST_POS]) begin
      settle_cnt  <= 2'h0;
      strap_valid <= 1'b0;
    end else if (!strap_valid) begin
      if (settle_cnt == 2'(iasr_pkg::STRAP_SETTLE - 1)) begin
        strap_orig  <= strap_s2;
        strap_valid <= 1'b1;
      end else begin
        settle_cnt <= settle_cnt + 2'h1;
      end
    end
  end

  // Reset bit requests, reserved bits dropped
  // Only writable bits
  assign rst_req = {3{wr_stb && wr_addr == iasr_pkg::RESET_CTRL_OFFSET}} &
                   {wr_data[iasr_pkg::VIDEO_RST_POS],
                    wr_data[iasr_pkg::FULL_RST_POS],
                    wr_data[iasr_pkg::LOGIC_RST_POS]};

  // One self-clearing pulse per reset bit
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_rst
      logic [4:0] cnt;  // Cycles the reset has been held
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          rst_bit[gi] <= iasr_pkg::RST_BITS_RESET[gi];
          cnt         <= 5'h00;
        end else if (rst_req[gi]) begin
          // A new write restarts the pulse
          rst_bit[gi] <= 1'b1;
          cnt         <= 5'h00;
        end else if (rst_bit[gi]) begin
          if (cnt == 5'(PULSE_CYCLES - 1)) begin
            rst_bit[gi] <= 1'b0;
          end else begin
            cnt <= cnt + 5'h01;
          end
        end
      end
    end
  endgenerate

  assign video_rx_reset                = rst_bit[2];
  assign full_logic_and_register_reset = rst_bit[1];
  assign logic_only_reset              = rst_bit[0];

  // Address register; held at default while either digital reset runs
  // Strap reload
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      target_address_field  <= 7'h00;
      address_source_select <= iasr_pkg::SRC_SEL_RESET;
    end else if (rst_bit[0] || rst_bit[1] || !strap_valid) begin
      target_address_field  <= strap_valid ? strap_orig : strap_s2;
      address_source_select <= iasr_pkg::SRC_SEL_RESET;
    end else if (wr_stb && wr_addr == iasr_pkg::OWN_ADDR_OFFSET) begin
      target_address_field  <= wr_data[7:iasr_pkg::FIELD_LSB];
      address_source_select <= wr_data[iasr_pkg::SRC_SEL_POS];
    end
  end

  // Address answered at
  // Source select
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      active_target_address <= 7'h00;
    end else begin
      active_target_address <= address_source_select ? target_address_field : strap_orig;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_data = iasr_pkg::UNMAPPED_READ;
    if (reg_ptr == iasr_pkg::OWN_ADDR_OFFSET) begin
      rd_data = {target_address_field, address_source_select};
    end else if (reg_ptr == iasr_pkg::RESET_CTRL_OFFSET) begin
      rd_data = {3'h0, rst_bit[2], 2'h0, rst_bit[1], rst_bit[0]};
    end
  end

  // Checks
  wire own_wr = wr_stb && wr_addr == iasr_pkg::OWN_ADDR_OFFSET;

  a_reserved_zero: assert property (@(posedge clk) disable iff (reset)
    reg_ptr == iasr_pkg::RESET_CTRL_OFFSET |-> (rd_data & ~iasr_pkg::RESET_CTRL_WRITABLE) == 8'h00)
    else $error("Reserved reset bits read nonzero");

  a_video_set: assert property (@(posedge clk) disable iff (reset)
    wr_stb && wr_addr == iasr_pkg::RESET_CTRL_OFFSET && wr_data[4] |=> video_rx_reset)
    else $error("Video reset not started by write");

  a_full_set: assert property (@(posedge clk) disable iff (reset)
    wr_stb && wr_addr == iasr_pkg::RESET_CTRL_OFFSET && wr_data[1]
    |=> full_logic_and_register_reset ##1 !strap_valid)
    else $error("Full reset not started or strap not recaught");

  a_logic_set: assert property (@(posedge clk) disable iff (reset)
    wr_stb && wr_addr == iasr_pkg::RESET_CTRL_OFFSET && wr_data[0] |=> logic_only_reset)
    else $error("Logic reset not started by write");

  a_self_clear: assert property (@(posedge clk) disable iff (reset)
    $rose(video_rx_reset) && !rst_req[2] |-> video_rx_reset[*2] ##[1:40] !video_rx_reset)
    else $error("Video reset did not self clear");

  a_strap_reload: assert property (@(posedge clk) disable iff (reset)
    logic_only_reset && strap_valid && !full_logic_and_register_reset
    |=> target_address_field == $past(strap_orig))
    else $error("Strap value not reloaded");

  a_src_default: assert property (@(posedge clk) disable iff (reset)
    $rose(logic_only_reset) |=> !address_source_select ##1 active_target_address == strap_orig)
    else $error("Address register not restored");

  a_prog_store: assert property (@(posedge clk) disable iff (reset)
    own_wr && strap_valid && !rst_bit[0] && !rst_bit[1]
    |=> {target_address_field, address_source_select} == $past(wr_data))
    else $error("Address register write lost");

  a_src_follow: assert property (@(posedge clk) disable iff (reset)
    address_source_select && $stable(address_source_select) && $stable(target_address_field)
    |=> active_target_address == $past(target_address_field))
    else $error("Programmed address not answered at");

  c_prog_addr: cover property (@(posedge clk) disable iff (reset)
    own_wr && wr_data[0]);
  c_logic_rst: cover property (@(posedge clk) disable iff (reset)
    $fell(logic_only_reset));
  c_full_rst: cover property (@(posedge clk) disable iff (reset)
    $fell(full_logic_and_register_reset));
  c_read_back: cover property (@(posedge clk) disable iff (reset)
    reg_ptr == iasr_pkg::RESET_CTRL_OFFSET && oe_int);

endmodule // iasr_regs

`default_nettype wire

// ---- verif/iasr_host_model.sv ----
`default_nettype none

// Serial bus host that reaches the register bank through its two pins
module iasr_host_model (
  input  wire logic clk,       // System clock paces every bus phase
  input  wire logic sda_line,  // Resolved data wire level
  output logic      scl,       // Bus clock, high when idle
  output logic      sda_low    // High pulls data low
);
  timeunit 1ns;
  timeprecision 1ns;

  localparam int HALF = 10;  // Phase length, keeps data clear of clock edges

  // Idle bus at time zero
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // Let clocks pass, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  // Data falls while clock high
  task automatic start_cond();
    sda_low = 1'b1;
    tick(HALF);
    scl = 1'b0;
    tick(HALF / 2);
  endtask

  // Release data first, then a fresh start
  task automatic restart_cond();
    sda_low = 1'b0;
    tick(HALF / 2);
    scl = 1'b1;
    tick(HALF);
    start_cond();
  endtask

  // Data rises while clock high
  task automatic stop_cond();
    sda_low = 1'b1;
    tick(HALF / 2);
    scl = 1'b1;
    tick(HALF);
    sda_low = 1'b0;
    tick(HALF);
  endtask

  // One bit out, changed only mid low phase
  task automatic put_bit(input logic b);
    sda_low = ~b;
    tick(HALF / 2);
    scl = 1'b1;
    tick(HALF);
    scl = 1'b0;
    tick(HALF / 2);
  endtask

  // One bit in, sampled mid high phase
  task automatic get_bit(output logic b);
    sda_low = 1'b0;
    tick(HALF / 2);
    scl = 1'b1;
    tick(HALF / 2);
    b = sda_line;
    tick(HALF / 2);
    scl = 1'b0;
    tick(HALF / 2);
  endtask

  // Byte out, most significant first, then the target's answer
  task automatic put_byte(input logic [7:0] v, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
      put_bit(v[i]);
    get_bit(b);
    ack = ~b;
  endtask

  // Byte in, then acknowledge or end the read
  task automatic get_byte(input logic last, output logic [7:0] v);
    for (int i = 7; i >= 0; i--)
      get_bit(v[i]);
    put_bit(last);
  endtask

  // Pointer and one data byte; ok only if all three were answered
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                           input logic [7:0] v, output logic ok);
    logic a0, a1, a2;
    start_cond();
    put_byte({dev, 1'b0}, a0);
    put_byte(ptr, a1);
    put_byte(v, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask

  // Set pointer, repeated start, one byte closed by a refusal
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr,
                          output logic [7:0] v, output logic ok);
    logic a0, a1, a2;
    start_cond();
    put_byte({dev, 1'b0}, a0);
    put_byte(ptr, a1);
    restart_cond();
    put_byte({dev, 1'b1}, a2);
    get_byte(1'b1, v);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask
endmodule // iasr_host_model

`default_nettype wire

// ---- verif/test_i2c_address_and_soft_reset_regs.sv ----
`default_nettype none

// Register bank driven over the serial bus by the host model
module test_i2c_address_and_soft_reset_regs;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int P = 6;        // Short reset pulse keeps the run brief
  logic       clk;             // System clock
  logic       reset;           // Power-on reset
  logic       scl;             // Bus clock from host
  logic       sda_low;         // Host pulls data low
  logic       sda_out;         // Device data level
  logic       sda_oe;          // Device pulls data low
  logic       sda_line;        // Resolved wire with pull-up
  logic [6:0] strap;           // Strap pin level
  logic [6:0] active;          // Address answered at
  logic [2:0] pulses;          // Video, full, logic-only
  logic [7:0] hits [3];        // High cycles per reset output
  logic [6:0] cur;             // Address the host uses now
  logic [6:0] capt;            // Strap caught by the device
  logic [7:0] v;               // Read data
  logic [7:0] wv;              // Written address register value
  logic       ok;              // All bytes answered
  logic       sel;             // Random source select
  int         bad_count;       // Mismatches
  int         num_checks;      // Comparisons
  int         seed;            // Seeding result

  // Pull-up wins unless someone drives low
  assign sda_line = (sda_oe ? sda_out : 1'b1) & ~sda_low;

  iasr_regs #(.PULSE_CYCLES(P)) DUT (
    .clk                           (clk),
    .reset                         (reset),
    .scl_in                        (scl),
    .sda_in                        (sda_line),
    .sda_out                       (sda_out),
    .sda_oe                        (sda_oe),
    .address_strap_pin             (strap),
    .active_target_address         (active),
    .video_rx_reset                (pulses[2]),
    .full_logic_and_register_reset (pulses[1]),
    .logic_only_reset              (pulses[0])
  );

  iasr_host_model host (
    .clk      (clk),
    .sda_line (sda_line),
    .scl      (scl),
    .sda_low  (sda_low)
  );

  // Free-running clock
  initial clk = 1'b0;
  always #25 clk = ~clk;

  // Count high cycles of each reset output
  always @(posedge clk) begin
    for (int j = 0; j < 3; j++)
      if (pulses[j] === 1'b1) hits[j] <= hits[j] + 8'h01;
  end

  // Compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Random address differing from two others
  function automatic logic [6:0] other_addr(input logic [6:0] a, input logic [6:0] b);
    logic [6:0] r;
    r = 7'($urandom());
    while (r == a || r == b)
      r = r + 7'h01;
    return r;
  endfunction

  // Address the device should answer at
  function automatic logic [6:0] exp_active(input logic [6:0] field, input logic s,
                                            input logic [6:0] st);
    return s ? field : st;
  endfunction

  // Program an address, move the strap, fire one reset bit, check what survived
  task automatic soft_case(input int k, input int pos);
    logic [6:0] prog, exp_a;
    prog = other_addr(cur, capt);
    host.write_reg(cur, 8'h00, {prog, 1'b1}, ok);
    cur = prog;
    check("address switch", {1'b0, active}, {1'b0, prog});
    strap = other_addr(capt, prog);
    for (int j = 0; j < 3; j++)
      hits[j] = 8'h00;
    host.write_reg(cur, 8'h01, 8'h01 << pos, ok);
    check("reset write ack", {7'h00, ok}, 8'h01);
    for (int j = 0; j < 3; j++)
      check("pulse cycles", hits[j], (j == k) ? 8'(P) : 8'h00);
    exp_a = (k == 2) ? prog : (k == 1) ? strap : capt;
    if (k == 1) capt = strap;
    check("address after", {1'b0, active}, {1'b0, exp_a});
    cur = exp_a;
    host.read_reg(cur, 8'h00, v, ok);
    check("address reg after", v, (k == 2) ? {prog, 1'b1} : {exp_a, 1'b0});
    host.read_reg(cur, 8'h01, v, ok);
    check("reset reg cleared", v, 8'h00);
  endtask

  // Bound on the whole run
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    results();
  end

  // Main sequence
  initial begin
    bad_count  = 0;
    num_checks = 0;
    seed       = $urandom(32'hb65e91b4);
    reset      = 1'b1;
    strap      = 7'($urandom());
    for (int j = 0; j < 3; j++)
      hits[j] = 8'h00;
    repeat (8) @(posedge clk);
    #5;
    check("address in reset", {1'b0, active}, 8'h00);
    reset = 1'b0;
    capt = strap;
    cur  = strap;
    host.tick(12);
    check("strap address", {1'b0, active}, {1'b0, strap});
    host.read_reg(cur, 8'h00, v, ok);
    check("address reg default", v, {strap, 1'b0});
    host.read_reg(cur, 8'h01, v, ok);
    check("reset reg default", v, 8'h00);
    host.read_reg(other_addr(cur, cur), 8'h00, v, ok);
    check("foreign address refused", {7'h00, ok}, 8'h00);
    host.write_reg(cur, 8'h01, 8'hec, ok);
    host.read_reg(cur, 8'h01, v, ok);
    check("reserved bits", v, 8'h00);
    check("no pulse", {5'h00, pulses}, 8'h00);
    check("no pulse seen", hits[0] | hits[1] | hits[2], 8'h00);
    // Random programmed addresses with random source select
    for (int i = 0; i < 4; i++) begin
      sel = 1'($urandom());
      wv  = {other_addr(cur, capt), sel};
      host.write_reg(cur, 8'h00, wv, ok);
      check("address write ack", {7'h00, ok}, 8'h01);
      cur = exp_active(wv[7:1], sel, capt);
      check("active address", {1'b0, active}, {1'b0, cur});
      host.read_reg(cur, 8'h00, v, ok);
      check("address reg", v, wv);
    end
    soft_case(2, 4);
    soft_case(0, 0);
    soft_case(1, 1);
    // Host follows full reset with a write of 02 to unmapped offset 4f
    host.write_reg(cur, 8'h4f, 8'h02, ok);
    check("bridge control ack", {7'h00, ok}, 8'h01);
    results();
  end
endmodule // test_i2c_address_and_soft_reset_regs

`default_nettype wire
